// [hw/nma_alu.sv]
// negate and long unsigned multiply datapath slice
`timescale 1ns/1ps
//
// How it works
// - multiplicand comes from low_product_reg; low product word written back there
// - width select 0 gives 32-bit product, 1 gives 64-bit pair
// - high product word goes to high_product_reg only when width select is 1
// - wide multiply with equal register fields has undefined result
// - multiply source accepts only data modes, not address register direct
// - decimal complement subtracts byte and extend bit from zero in BCD
// - extend clear yields tens complement, extend set yields nines complement
// - decimal complement: N,V undefined, Z sticky-clear, C borrow, X copies C
// - negate destinations accept only data alterable modes
// - size field 00 byte, 01 word, 10 long
// - twos complement subtracts destination from zero at size, writes back
// - twos complement flags N,Z,V from result; C set unless zero; X copies C
// - extended complement subtracts destination and extend bit from zero
// - extended complement: N from result, V from destination and result signs, Z sticky-clear, C borrow, X copies C
// - multiply is unsigned on both operands
// - narrow multiply: V when upper half nonzero, N,Z from result, C clear
module nma_alu
    import nma_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic [15:0] opcode,
    input wire logic [15:0] ext_word,
    input wire logic [31:0] src_operand,
    input wire logic [31:0] dst_operand,
    input wire logic [4:0] ccr_in,
    output logic res_valid,
    output logic illegal_op,
    output logic [31:0] res_low,
    output logic [31:0] res_high,
    output logic wr_low_en,
    output logic wr_high_en,
    output logic [2:0] low_reg_sel,
    output logic [2:0] high_reg_sel,
    output logic [1:0] res_size,
    output logic [4:0] ccr_out,
    output logic ccr_wr
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic loc_ok(input logic [5:0] loc, input logic alterable);
        logic [2:0] md;
        logic [2:0] rg;
        md = loc[5:3];
        rg = loc[2:0];
        if (md == NMA_MODE_AREG) begin
            loc_ok = 1'b0;
        end else if (md == NMA_MODE_EXT) begin
            loc_ok = (rg == NMA_REG_ABS_W) || (rg == NMA_REG_ABS_L) ||
                     (!alterable && ((rg == NMA_REG_IMM) || (rg == NMA_REG_PC_D) || (rg == NMA_REG_PC_X)));
        end else begin
            loc_ok = 1'b1;
        end
    endfunction

    function automatic logic msb_at(input logic [31:0] v, input logic [1:0] sz);
        case (sz)
            NMA_SZ_BYTE: msb_at = v[7];
            NMA_SZ_WORD: msb_at = v[15];
            default: msb_at = v[31];
        endcase
    endfunction

    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        case (sz)
            NMA_SZ_BYTE: size_mask = 32'h0000_00FF;
            NMA_SZ_WORD: size_mask = 32'h0000_FFFF;
            default: size_mask = 32'hFFFF_FFFF;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic s1_valid;
        nma_op_e s1_op;
        logic s1_illegal;
        logic [1:0] s1_size;
        logic s1_wide;
        logic [2:0] s1_lo_sel;
        logic [2:0] s1_hi_sel;
        logic [31:0] s1_dst;
        logic [4:0] s1_ccr;
        logic res_valid;
        logic illegal_op;
        logic [31:0] res_low;
        logic [31:0] res_high;
        logic wr_low_en;
        logic wr_high_en;
        logic [2:0] low_reg_sel;
        logic [2:0] high_reg_sel;
        logic [1:0] res_size;
        logic [4:0] ccr_out;
        logic ccr_wr;
    } nma_alu_s;

    nma_alu_s st_r;
    nma_alu_s st_nxt;
    logic [63:0] product;

    nma_mult u_mult (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .multiplicand(dst_operand),
        .multiplier(src_operand),
        .product(product)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode and execute

    always_comb begin
        logic [1:0] sz;
        logic [4:0] dlo;
        logic [4:0] dhi;
        logic [3:0] nlo;
        logic [3:0] nhi;
        logic [32:0] diff;
        logic [31:0] mask;
        logic [31:0] rv;
        logic xin;
        logic dm;
        logic rm;
        logic nz;
        logic [4:0] cc;
        sz = opcode[NMA_SIZE_HI:NMA_SIZE_LO];
        dlo = 5'h00;
        dhi = 5'h00;
        nlo = 4'h0;
        nhi = 4'h0;
        diff = 33'h0_0000_0000;
        mask = 32'h0000_0000;
        rv = 32'h0000_0000;
        xin = 1'b0;
        dm = 1'b0;
        rm = 1'b0;
        nz = 1'b0;
        cc = 5'h00;
        st_nxt = st_r;

        // stage 1: decode
        st_nxt.s1_valid = op_valid;
        st_nxt.s1_dst = dst_operand;
        st_nxt.s1_ccr = ccr_in;
        st_nxt.s1_size = sz;
        st_nxt.s1_wide = ext_word[NMA_EXT_WIDE];
        st_nxt.s1_lo_sel = ext_word[NMA_EXT_LO_HI:NMA_EXT_LO_LO];
        st_nxt.s1_hi_sel = ext_word[NMA_EXT_HI_HI:NMA_EXT_HI_LO];
        st_nxt.s1_op = NMA_OP_NONE;
        st_nxt.s1_illegal = 1'b1;
        if (opcode[NMA_OPC_HI:NMA_OPC_LO] == NMA_OPC_MUL) begin
            st_nxt.s1_op = NMA_OP_MUL;
            st_nxt.s1_size = NMA_SZ_LONG;
            st_nxt.s1_illegal = !loc_ok(opcode[5:0], 1'b0) || ext_word[NMA_EXT_SIGNED] ||
                                ((ext_word & NMA_EXT_ZERO_MASK) != 16'h0000);
        end else if (opcode[NMA_OPC_HI:NMA_OPC_LO] == NMA_OPC_BCD) begin
            st_nxt.s1_op = NMA_OP_BCD;
            st_nxt.s1_size = NMA_SZ_BYTE;
            st_nxt.s1_illegal = !loc_ok(opcode[5:0], 1'b1);
        end else if (opcode[NMA_OPC_HI:NMA_SIZE_HI + 1] == NMA_OPC_NEG) begin
            st_nxt.s1_op = NMA_OP_NEG;
            st_nxt.s1_illegal = !loc_ok(opcode[5:0], 1'b1) || (sz == 2'h3);
        end else if (opcode[NMA_OPC_HI:NMA_SIZE_HI + 1] == NMA_OPC_EXTENDED_COMPLEMENT_OP) begin
            st_nxt.s1_op = NMA_OP_EXTENDED_COMPLEMENT_OP;
            st_nxt.s1_illegal = !loc_ok(opcode[5:0], 1'b1) || (sz == 2'h3);
        end

        // stage 2: execute
        cc = st_r.s1_ccr;
        xin = st_r.s1_ccr[NMA_F_X];
        mask = size_mask(st_r.s1_size);
        rv = st_r.s1_dst;
        st_nxt.res_valid = st_r.s1_valid;
        st_nxt.illegal_op = st_r.s1_valid && st_r.s1_illegal;
        st_nxt.res_size = st_r.s1_size;
        st_nxt.low_reg_sel = st_r.s1_lo_sel;
        st_nxt.high_reg_sel = st_r.s1_hi_sel;
        st_nxt.res_high = 32'h0000_0000;
        case (st_r.s1_op)
            NMA_OP_MUL: begin
                rv = product[31:0];
                st_nxt.res_high = product[63:32];
                if (st_r.s1_wide) begin
                    cc[NMA_F_N] = product[63];
                    cc[NMA_F_Z] = (product == 64'h0000_0000_0000_0000);
                    cc[NMA_F_V] = 1'b0;
                end else begin
                    cc[NMA_F_N] = product[31];
                    cc[NMA_F_Z] = (product[31:0] == 32'h0000_0000);
                    cc[NMA_F_V] = (product[63:32] != 32'h0000_0000);
                end
                cc[NMA_F_C] = 1'b0;
            end
            NMA_OP_BCD: begin
                dlo = 5'h00 - {1'b0, st_r.s1_dst[3:0]} - {4'h0, xin};
                nlo = dlo[4] ? (dlo[3:0] - NMA_BCD_ADJ) : dlo[3:0];
                dhi = 5'h00 - {1'b0, st_r.s1_dst[7:4]} - {4'h0, dlo[4]};
                nhi = dhi[4] ? (dhi[3:0] - NMA_BCD_ADJ) : dhi[3:0];
                rv = {st_r.s1_dst[31:8], nhi, nlo};
                if ({nhi, nlo} != 8'h00) begin
                    cc[NMA_F_Z] = 1'b0;
                end
                cc[NMA_F_C] = dhi[4];
                cc[NMA_F_X] = dhi[4];
            end
            NMA_OP_NEG, NMA_OP_EXTENDED_COMPLEMENT_OP: begin
                xin = (st_r.s1_op == NMA_OP_EXTENDED_COMPLEMENT_OP) && xin;
                diff = 33'h0_0000_0000 - {1'b0, st_r.s1_dst & mask} - {32'h0000_0000, xin};
                rv = (st_r.s1_dst & ~mask) | (diff[31:0] & mask);
                dm = msb_at(st_r.s1_dst, st_r.s1_size);
                rm = msb_at(diff[31:0], st_r.s1_size);
                nz = ((diff[31:0] & mask) != 32'h0000_0000);
                cc[NMA_F_N] = rm;
                cc[NMA_F_V] = dm & rm;
                if (st_r.s1_op == NMA_OP_NEG) begin
                    cc[NMA_F_Z] = !nz;
                    cc[NMA_F_C] = nz;
                end else begin
                    if (nz) begin
                        cc[NMA_F_Z] = 1'b0;
                    end
                    cc[NMA_F_C] = dm | rm;
                end
                cc[NMA_F_X] = cc[NMA_F_C];
            end
            default: begin
                cc = st_r.s1_ccr;
            end
        endcase
        st_nxt.res_low = rv;
        st_nxt.ccr_out = cc;
        st_nxt.ccr_wr = st_r.s1_valid && !st_r.s1_illegal;
        st_nxt.wr_low_en = st_r.s1_valid && !st_r.s1_illegal;
        // equal fields with wide set write both; partner order decides
        st_nxt.wr_high_en = st_r.s1_valid && !st_r.s1_illegal &&
                            (st_r.s1_op == NMA_OP_MUL) && st_r.s1_wide;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{s1_op: NMA_OP_NONE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign res_valid = st_r.res_valid;
    assign illegal_op = st_r.illegal_op;
    assign res_low = st_r.res_low;
    assign res_high = st_r.res_high;
    assign wr_low_en = st_r.wr_low_en;
    assign wr_high_en = st_r.wr_high_en;
    assign low_reg_sel = st_r.low_reg_sel;
    assign high_reg_sel = st_r.high_reg_sel;
    assign res_size = st_r.res_size;
    assign ccr_out = st_r.ccr_out;
    assign ccr_wr = st_r.ccr_wr;

endmodule

// [hw/nma_pkg.sv]
// shared constants and types for the negate/multiply datapath slice
package nma_pkg;

    localparam int NMA_LATENCY = 2;

    // opcode word fields
    localparam int NMA_OPC_HI = 15;
    localparam int NMA_OPC_LO = 6;
    localparam int NMA_SIZE_HI = 7;
    localparam int NMA_SIZE_LO = 6;
    localparam logic [9:0] NMA_OPC_MUL = 10'h130;
    localparam logic [9:0] NMA_OPC_BCD = 10'h120;
    localparam logic [7:0] NMA_OPC_NEG = 8'h44;
    localparam logic [7:0] NMA_OPC_EXTENDED_COMPLEMENT_OP = 8'h40;

    // multiply extension word fields
    localparam int NMA_EXT_LO_HI = 14;
    localparam int NMA_EXT_LO_LO = 12;
    localparam int NMA_EXT_SIGNED = 11;
    localparam int NMA_EXT_WIDE = 10;
    localparam int NMA_EXT_HI_HI = 2;
    localparam int NMA_EXT_HI_LO = 0;
    localparam logic [15:0] NMA_EXT_ZERO_MASK = 16'h83F8;

    // operand locator modes
    localparam logic [2:0] NMA_MODE_AREG = 3'h1;
    localparam logic [2:0] NMA_MODE_EXT = 3'h7;
    localparam logic [2:0] NMA_REG_ABS_W = 3'h0;
    localparam logic [2:0] NMA_REG_ABS_L = 3'h1;
    localparam logic [2:0] NMA_REG_PC_D = 3'h2;
    localparam logic [2:0] NMA_REG_PC_X = 3'h3;
    localparam logic [2:0] NMA_REG_IMM = 3'h4;

    // sizes
    localparam logic [1:0] NMA_SZ_BYTE = 2'h0;
    localparam logic [1:0] NMA_SZ_WORD = 2'h1;
    localparam logic [1:0] NMA_SZ_LONG = 2'h2;

    // flag positions in the condition byte
    localparam int NMA_F_X = 4;
    localparam int NMA_F_N = 3;
    localparam int NMA_F_Z = 2;
    localparam int NMA_F_V = 1;
    localparam int NMA_F_C = 0;

    localparam logic [3:0] NMA_BCD_ADJ = 4'h6;

    typedef enum logic [4:0] {
        NMA_OP_NONE = 5'b00001,
        NMA_OP_MUL = 5'b00010,
        NMA_OP_BCD = 5'b00100,
        NMA_OP_NEG = 5'b01000,
        NMA_OP_EXTENDED_COMPLEMENT_OP = 5'b10000
    } nma_op_e;

endpackage

// [hw/nma_mult.sv]
// registered 32 by 32 unsigned multiplier stage
`timescale 1ns/1ps
module nma_mult
    import nma_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [31:0] multiplicand,
    input wire logic [31:0] multiplier,
    output logic [63:0] product
);

    typedef struct packed {
        logic [63:0] prod;
    } nma_mult_s;

    nma_mult_s st_r;
    nma_mult_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.prod = {32'h0000_0000, multiplicand} * {32'h0000_0000, multiplier};
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign product = st_r.prod;

endmodule

// [dv/nma_alu_props.sv]
// concurrent checks on the ports of the negate/multiply datapath
`timescale 1ns/1ps
module nma_alu_props
    import nma_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic [15:0] opcode,
    input wire logic [15:0] ext_word,
    input wire logic [31:0] src_operand,
    input wire logic [31:0] dst_operand,
    input wire logic [4:0] ccr_in,
    input wire logic res_valid,
    input wire logic illegal_op,
    input wire logic [31:0] res_low,
    input wire logic [31:0] res_high,
    input wire logic wr_low_en,
    input wire logic wr_high_en,
    input wire logic [2:0] low_reg_sel,
    input wire logic [2:0] high_reg_sel,
    input wire logic [1:0] res_size,
    input wire logic [4:0] ccr_out,
    input wire logic ccr_wr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    a_result_latency: assert property (op_valid |-> ##2 res_valid) else $error("result late");
    a_no_stray_result: assert property (res_valid |-> $past(op_valid, 2)) else $error("stray result");
    a_refused_quiet: assert property (res_valid && illegal_op |-> !wr_low_en && !wr_high_en && !ccr_wr)
        else $error("refused op wrote");
    a_areg_source_refused: assert property (op_valid && opcode[15:6] == NMA_OPC_MUL
        && opcode[5:3] == NMA_MODE_AREG |-> ##2 illegal_op) else $error("address source taken");
    a_dest_mode_refused: assert property (op_valid && (opcode[15:6] == NMA_OPC_BCD
        || opcode[15:8] == NMA_OPC_NEG) && (opcode[5:3] == NMA_MODE_AREG || opcode[5:0] > 6'h39)
        |-> ##2 res_valid && illegal_op) else $error("bad destination taken");
    a_high_word_wide: assert property (wr_high_en |-> $past(ext_word[NMA_EXT_WIDE], 2)
        && high_reg_sel == $past(ext_word[2:0], 2)) else $error("high word write wrong");
    a_low_reg_echo: assert property (wr_low_en && $past(opcode[15:6], 2) == NMA_OPC_MUL
        |-> low_reg_sel == $past(ext_word[14:12], 2)) else $error("low register wrong");
    a_neg_long_value: assert property (ccr_wr && $past(opcode[15:6], 2) == {NMA_OPC_NEG, NMA_SZ_LONG}
        |-> res_low == 32'h0 - $past(dst_operand, 2) && ccr_out[NMA_F_C] == (res_low != 32'h0))
        else $error("long negate wrong");
    a_narrow_overflow: assert property (ccr_wr && $past(opcode[15:6], 2) == NMA_OPC_MUL
        && !$past(ext_word[NMA_EXT_WIDE], 2) |-> !ccr_out[NMA_F_C] && ccr_out[NMA_F_V] ==
        ((64'($past(src_operand, 2)) * 64'($past(dst_operand, 2))) >> 32 != 64'h0)) else $error("overflow wrong");
    a_extend_copies_borrow: assert property (ccr_wr && $past(opcode[15:6], 2) != NMA_OPC_MUL
        |-> ccr_out[NMA_F_X] == ccr_out[NMA_F_C]) else $error("extend not borrow");
    a_zero_stays_clear: assert property (ccr_wr && $past(opcode[15:6], 2) == NMA_OPC_BCD
        && !$past(ccr_in[NMA_F_Z], 2) |-> !ccr_out[NMA_F_Z]) else $error("zero flag set");
    c_wide: cover property (wr_high_en);
    c_illegal: cover property (res_valid && illegal_op);
    c_bcd: cover property (ccr_wr && $past(opcode[15:6], 2) == NMA_OPC_BCD);
endmodule
bind nma_alu nma_alu_props nma_alu_props_i (.clk_sys, .resetn, .op_valid, .opcode, .ext_word, .src_operand,
    .dst_operand, .ccr_in, .res_valid, .illegal_op, .res_low, .res_high, .wr_low_en, .wr_high_en,
    .low_reg_sel, .high_reg_sel, .res_size, .ccr_out, .ccr_wr);

// [dv/nma_core_model.sv]
// flag register of the surrounding core, fed back as ccr_in
`timescale 1ns/1ps
module nma_core_model
    import nma_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic load_en,
    input wire logic [4:0] load_val,
    input wire logic [4:0] ccr_out,
    input wire logic ccr_wr,
    output logic [4:0] ccr_in
);
    // no forwarding: new flags show one edge after the write pulse
    // a bench load wins over a write landing in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ccr_in <= 5'h00;
        end else if (load_en) begin
            ccr_in <= load_val;
        end else if (ccr_wr) begin
            ccr_in <= ccr_out;
        end
    end
endmodule

// [dv/tb_negate_multiply_alu.sv]
// self-checking bench for the negate/multiply datapath
`timescale 1ns/1ps
module tb_negate_multiply_alu;
    import nma_pkg::*;
    typedef struct packed {logic [15:0] opc, ext; logic [31:0] src, dst; logic [4:0] cin, cx; logic [31:0] lo, hi;
        logic ill;} nma_row_s;
    nma_row_s rows [18];
    logic clk_sys, resetn, op_valid, load_en, res_valid, illegal_op, wr_low_en, wr_high_en, ccr_wr;
    logic [15:0] opcode, ext_word;
    logic [31:0] src_operand, dst_operand, res_low, res_high;
    logic [4:0] load_val, ccr_in, ccr_out;
    logic [2:0] low_reg_sel, high_reg_sel;
    logic [1:0] res_size;
    int bad_count, comparisons, cycles;
    nma_alu nma_alu_i (.clk_sys, .resetn, .op_valid, .opcode, .ext_word, .src_operand, .dst_operand, .ccr_in,
        .res_valid, .illegal_op, .res_low, .res_high, .wr_low_en, .wr_high_en, .low_reg_sel, .high_reg_sel,
        .res_size, .ccr_out, .ccr_wr);
    nma_core_model nma_core_model_i (.clk_sys, .resetn, .load_en, .load_val, .ccr_out, .ccr_wr, .ccr_in);
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic issue(input logic [15:0] opc, input logic [15:0] ext, input logic [31:0] src, dst);
        opcode = opc;
        ext_word = ext;
        src_operand = src;
        dst_operand = dst;
        op_valid = 1'b1;
        @(negedge clk_sys);
    endtask
    task automatic wait_res();
        int n;
        n = 0;
        op_valid = 1'b0;
        while (res_valid !== 1'b1 && n < 6) begin
            @(negedge clk_sys);
            n++;
        end
        check(res_valid, 1'b1);
    endtask
    task automatic setf(input logic [4:0] v);
        load_en = 1'b1;
        load_val = v;
        @(negedge clk_sys);
        load_en = 1'b0;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        resetn = 1'b0;
        op_valid = 1'b0;
        load_en = 1'b0;
        load_val = '0;
        opcode = '0;
        ext_word = '0;
        src_operand = '0;
        dst_operand = '0;
        bad_count = 0;
        comparisons = 0;
        cycles = 0;
        rows = '{'{16'h4C01, 16'h1402, 32'hFFFFFFFF, 32'h2, 5'h10, 5'h10, 32'hFFFFFFFE, 32'h1, 0},
            '{16'h4C3C, 16'h1000, 32'hFFFFFFFF, 32'h2, 5'h00, 5'h0A, 32'hFFFFFFFE, '0, 0},
            '{16'h4C3A, 16'h2000, 32'h3, 32'h5, 5'h1F, 5'h10, 32'hF, '0, 0},
            '{16'h4C09, 16'h1000, '0, '0, '0, '0, '0, '0, 1}, '{16'h4C00, 16'h1800, '0, '0, '0, '0, '0, '0, 1},
            '{16'h4430, '0, '0, 32'h12345680, 5'h00, 5'h1B, 32'h12345680, '0, 0},
            '{16'h4450, '0, '0, 32'hAAAA0000, 5'h1F, 5'h04, 32'hAAAA0000, '0, 0},
            '{16'h44A0, '0, '0, 32'h1, 5'h00, 5'h19, 32'hFFFFFFFF, '0, 0},
            '{16'h44C0, '0, '0, '0, '0, '0, '0, '0, 1}, '{16'h4488, '0, '0, '0, '0, '0, '0, '0, 1},
            '{16'h44BA, '0, '0, '0, '0, '0, '0, '0, 1}, '{16'h403C, '0, '0, '0, '0, '0, '0, '0, 1},
            '{16'h4038, '0, '0, 32'h0, 5'h14, 5'h19, 32'hFF, '0, 0},
            '{16'h4079, '0, '0, 32'h0, 5'h04, 5'h04, 32'h0, '0, 0},
            '{16'h40A8, '0, '0, 32'h80000000, 5'h00, 5'h1B, 32'h80000000, '0, 0},
            '{16'h4800, '0, '0, 32'h1, 5'h04, 5'h11, 32'h99, '0, 0},
            '{16'h4818, '0, '0, 32'hFFFFFF42, 5'h10, 5'h11, 32'hFFFFFF57, '0, 0},
            '{16'h483C, '0, '0, '0, '0, '0, '0, '0, 1}};
        repeat (12) @(negedge clk_sys);
        resetn = 1;
        check({res_valid, wr_low_en, ccr_wr, ccr_out}, '0);
        foreach (rows[i]) begin
            setf(rows[i].cin);
            issue(rows[i].opc, rows[i].ext, rows[i].src, rows[i].dst);
            wait_res();
            check(illegal_op, rows[i].ill);
            if (!rows[i].ill) check(res_size, (rows[i].opc[11:8] == 4'hC) ? NMA_SZ_LONG :
                ((rows[i].opc[11:8] == 4'h8) ? NMA_SZ_BYTE : rows[i].opc[7:6]));
            check({wr_low_en, ccr_wr}, {2{!rows[i].ill}});
            check(wr_high_en, !rows[i].ill && rows[i].ext[NMA_EXT_WIDE]);
            if (!rows[i].ill) check(res_low, rows[i].lo);
            if (!rows[i].ill) check(ccr_out, rows[i].cx);
            if (wr_high_en) check({res_high, high_reg_sel}, {rows[i].hi, rows[i].ext[2:0]});
        end
        setf(5'h04);
        issue(16'h4040, '0, '0, 32'h0);
        issue(16'h4480, '0, '0, 32'h1);
        wait_res();
        check({res_low, ccr_out}, {32'h0, 5'h04});
        @(negedge clk_sys);
        check({res_valid, res_low, ccr_out}, {1'b1, 32'hFFFFFFFF, 5'h19});
        // flags of the last write reach the core one edge later
        @(negedge clk_sys);
        issue(16'h4000, '0, '0, 32'h0);
        wait_res();
        check({res_low, ccr_out}, {32'hFF, 5'h19});
        issue(16'h4480, '0, '0, 32'h1);
        op_valid = 0;
        resetn = 0;
        repeat (4) begin
            @(negedge clk_sys);
            resetn = 1;
            check(res_valid, 1'b0);
        end
        issue(16'h4480, '0, '0, 32'h1);
        wait_res();
        check({res_low, ccr_out}, {32'hFFFFFFFF, 5'h19});
        end_sim();
    end
endmodule
